// File: verif/master_model.sv
// master station model across the cyclic link
module master_model #(
  parameter int DELAY = 20
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench commands
  input wire logic want_set,
  input wire logic want_err_reset,
  // system area flags
  input wire logic [15:0] dev_flags,
  output logic [15:0] master_flags
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // reserved flags stay low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_flags <= 16'h0000;
      cnt <= 0;
    end else begin
      cnt <= dev_flags[8] ? cnt + 1 : cnt;
      // late completion on purpose, so the slow path is seen
      master_flags[8] <= master_flags[8] | (cnt >= DELAY);
      master_flags[9] <= want_set;
      // request only after the cause is cleared, held until the flag drops
      master_flags[10] <= want_err_reset & dev_flags[10];
    end
  end
endmodule : master_model

// File: verif/sys_area_monitor.sv
// assertions on the system-area handshake ports
module sys_area_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic major_err,
  input wire logic minor_err,
  input wire logic minor_cause_gone,
  input wire logic [15:0] link_output_bits,
  input wire logic [15:0] link_input_bits,
  input wire logic [15:0] link_input_words,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] f;
  logic rst_seen;
  assign f = link_input_bits | link_input_words;
  // first edge is skipped: flops only settle once reset has been sampled
  always_ff @(posedge pclk) rst_seen <= !presetn;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_err_on;
    major_err ##1 f[10];
  endsequence
  a_err_ready: assert property (s_err_on |=> !f[11])
    else $error("ready during error");
  a_err_clear: assert property ($rose(link_output_bits[10]) && !major_err |=> !f[10])
    else $error("error flag kept");
  a_warn_set: assert property (minor_err |=> f[7])
    else $error("warning missed");
  a_warn_clear: assert property (minor_cause_gone && !minor_err |=> !f[7])
    else $error("warning kept");
  a_warn_keeps: assert property ($rose(f[7]) && $past(f[11]) && !$past(f[10]) |-> f[11])
    else $error("warning dropped ready");
  a_proc_drop: assert property (f[8] && link_output_bits[8] |=> !f[8])
    else $error("request kept");
  a_ready_cause: assert property ($rose(f[11]) |-> !f[8] && !f[10] && !$past(f[10]))
    else $error("ready too early");
  a_reset_zero: assert property (disable iff (1'b0) rst_seen && !presetn |-> f == 16'h0 && !irq)
    else $error("flags in reset");
endmodule : sys_area_monitor
bind sys_area_handshake sys_area_monitor mon (.*);

// File: verif/testbench.sv
// self-checking bench for the system-area handshake
module testbench
  import sys_area_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, irq, major_err = 1'b0, minor_err = 1'b0, minor_cause_gone = 1'b0;
  logic [15:0] ecode = 16'h0, wcode = 16'h0, mflags, ibits, iwords, f;
  logic want_set = 1'b0, want_rst = 1'b0, slverr;
  logic [11:0] start;
  int n_mismatch = 0, cmp_count = 0;
  assign f = ibits | iwords;
  always #4 pclk = ~pclk;
  sys_area_handshake dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(slverr), .major_err(major_err), .major_err_code(ecode),
    .minor_err(minor_err), .minor_err_code(wcode), .minor_cause_gone(minor_cause_gone),
    .link_output_bits(mflags), .link_output_words(mflags), .link_input_bits(ibits),
    .link_input_words(iwords), .area_start(start), .irq(irq));
  master_model mst (.pclk(pclk), .presetn(presetn), .want_set(want_set),
    .want_err_reset(want_rst), .dev_flags(f), .master_flags(mflags));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // entered just after a rising edge; holds the request until pready is sampled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_mismatch++;
      complete_run();
    end
    // one idle edge, so the next call never reassigns psel in this time step
    @(posedge pclk);
  endtask : apb
  task automatic wt(input int b, input logic v);
    int n;
    n = 0;
    while (f[b] !== v && n < 60) begin
      @(posedge pclk);
      n++;
    end
    chk("flag", {31'h0, v}, {31'h0, f[b]});
    if (n >= 60) complete_run();
  endtask : wt
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk("flags in reset", 32'h0, {16'h0, f});
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl", {27'h0, CTRL_RESET}, q);
    apb(1'b0, 12'h01c, 32'h0);
    chk("unmapped", 32'h0, q);
    chk("slverr", 32'h0, {31'h0, slverr});
    apb(1'b1, ADDR_START, 32'h123);
    chk("start pin", 32'h123, {20'h0, start});
    apb(1'b0, ADDR_START, 32'h0);
    chk("start reg", 32'h123, q);
    $display("reset test done");
    apb(1'b1, ADDR_CTRL, 32'h7);
    wt(8, 1'b1);
    wt(8, 1'b0);
    repeat (4) @(posedge pclk);
    chk("ready early", 32'h0, {31'h0, f[11]});
    want_set <= 1'b1;
    apb(1'b1, ADDR_CTRL, 32'hf);
    wt(9, 1'b1);
    wt(11, 1'b1);
    chk("area", 32'h0a00, {16'h0, ibits});
    $display("handshake test done");
    wcode <= 16'h5a3c;
    minor_err <= 1'b1;
    @(posedge pclk);
    minor_err <= 1'b0;
    wt(7, 1'b1);
    chk("ready warn", 32'h1, {31'h0, f[11]});
    apb(1'b0, ADDR_WARN_CODE, 32'h0);
    chk("warn code", 32'h5a3c, q);
    minor_cause_gone <= 1'b1;
    @(posedge pclk);
    minor_cause_gone <= 1'b0;
    wt(7, 1'b0);
    apb(1'b0, ADDR_WARN_CODE, 32'h0);
    chk("warn code", 32'h0, q);
    $display("warning test done");
    apb(1'b1, ADDR_MASK, 32'h1);
    apb(1'b0, ADDR_EVENT, 32'h0);
    chk("events", 32'he, q);
    chk("irq masked", 32'h0, {31'h0, irq});
    ecode <= 16'hc0de;
    major_err <= 1'b1;
    @(posedge pclk);
    major_err <= 1'b0;
    wt(10, 1'b1);
    wt(11, 1'b0);
    apb(1'b0, ADDR_ERR_CODE, 32'h0);
    chk("err code", 32'hc0de, q);
    want_rst <= 1'b1;
    wt(10, 1'b0);
    want_rst <= 1'b0;
    apb(1'b0, ADDR_ERR_CODE, 32'h0);
    chk("err code", 32'h0, q);
    wt(11, 1'b1);
    chk("irq set", 32'h1, {31'h0, irq});
    apb(1'b1, ADDR_EVENT, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq clear", 32'h0, {31'h0, irq});
    $display("error test done");
    apb(1'b1, ADDR_CTRL, 32'h1f);
    repeat (3) @(posedge pclk);
    chk("bit area", 32'h0, {16'h0, ibits});
    chk("word area", 32'h0a00, {16'h0, iwords});
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status", 32'h00010300, q);
    $display("word area test done");
    complete_run();
  end
endmodule : testbench

// File: verilog/sys_area_handshake.sv
// device-side system-area handshake with apb register access
// Behaviour
// - remote ready only when exchange possible after reset
// - warning alone keeps remote ready up
// - raise processing request after reset; master completes
// - ready waits for processing exchange when enabled
// - setting request answered by setting complete
// - ready follows applied setting when enabled
// - both exchanges done before ready
// - error flag set on moderate/major error
// - reset request clears error flag and code
// - ready low from error until cleared
// - warning flag set on minor error
// - warning cleared once master removes cause
// - sixteen-bit area from start number, rest reserved
// - layout may sit in word areas instead
//
// The implementer's own choices: the APB slave port and the register addresses.
module sys_area_handshake
  import sys_area_pkg::*;
#(
  parameter int unsigned START_W = 12,
  parameter int unsigned CODE_W = 16
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // local error sources
  input wire logic major_err,
  input wire logic [CODE_W-1:0] major_err_code,
  input wire logic minor_err,
  input wire logic [CODE_W-1:0] minor_err_code,
  input wire logic minor_cause_gone,
  // system area as seen from the link
  input wire logic [AREA_BITS-1:0] link_output_bits,
  input wire logic [AREA_BITS-1:0] link_output_words,
  output logic [AREA_BITS-1:0] link_input_bits,
  output logic [AREA_BITS-1:0] link_input_words,
  output logic [START_W-1:0] area_start,
  // interrupt
  output logic irq
);

  hs_state_e state;
  logic [4:0] ctrl;
  logic [3:0] event_st;
  logic [3:0] mask;
  logic [CODE_W-1:0] err_code;
  logic [CODE_W-1:0] warn_code;
  logic warn_flag;
  logic err_flag;
  logic proc_req;
  logic proc_done;
  logic set_done;
  logic ready;
  logic [AREA_BITS-1:0] area_out;
  logic [AREA_BITS-1:0] area_in;
  logic master_proc_done;
  logic master_set_req;
  logic master_err_reset;
  logic err_reset_d;
  logic wr;
  logic [3:0] ev_set;
  logic exchange_done;

  // the partner's flags come from bits or words depending on placement
  assign area_out = ctrl[CTRL_WORD_AREA] ? link_output_words : link_output_bits;
  assign master_proc_done = area_out[POS_INIT_PROC];
  assign master_set_req = area_out[POS_INIT_SET];
  assign master_err_reset = area_out[POS_ERROR];

  assign wr = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // handshake state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= st_init;
    end else begin
      case (state)
        st_init: begin
          if (err_flag) begin
            state <= st_error;
          end else if (exchange_done) begin
            state <= st_run;
          end
        end
        st_run: begin
          if (err_flag) begin
            state <= st_error;
          end
        end
        st_error: begin
          if (!err_flag) begin
            state <= exchange_done ? st_run : st_init;
          end
        end
        default: state <= st_init;
      endcase
    end
  end

  // initial data processing request stays up until the master completes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      proc_req <= 1'b0;
      proc_done <= 1'b0;
    end else if (!ctrl[CTRL_PROC_EN]) begin
      proc_req <= 1'b0;
      proc_done <= 1'b1;
    end else if (!proc_done) begin
      proc_req <= !master_proc_done;
      proc_done <= master_proc_done;
    end else begin
      proc_req <= 1'b0;
    end
  end

  // setting complete is held once set, even after the master withdraws its request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      set_done <= 1'b0;
    end else if (!ctrl[CTRL_SET_EN]) begin
      set_done <= 1'b1;
    end else if (master_set_req && ctrl[CTRL_SET_APPLIED]) begin
      set_done <= 1'b1;
    end else if (!master_set_req && set_done && proc_done) begin
      set_done <= set_done;
    end
  end

  assign exchange_done = proc_done && set_done;

  // the reset request acts on its rising edge, so a request held high clears once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_reset_d <= 1'b0;
    end else begin
      err_reset_d <= master_err_reset;
    end
  end

  logic err_reset_req;
  assign err_reset_req = master_err_reset && !err_reset_d;

  // error flag; a new error in the reset cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_flag <= 1'b0;
    end else if (major_err) begin
      err_flag <= 1'b1;
    end else if (err_reset_req) begin
      err_flag <= 1'b0;
    end
  end

  // stored error code follows the flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_code <= '0;
    end else if (major_err) begin
      err_code <= major_err_code;
    end else if (err_reset_req) begin
      err_code <= '0;
    end
  end

  // warning flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn_flag <= 1'b0;
    end else if (minor_err) begin
      warn_flag <= 1'b1;
    end else if (minor_cause_gone) begin
      warn_flag <= 1'b0;
    end
  end

  // stored warning code follows the flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn_code <= '0;
    end else if (minor_err) begin
      warn_code <= minor_err_code;
    end else if (minor_cause_gone) begin
      warn_code <= '0;
    end
  end

  // warning is not a term here, so a minor error never drops ready;
  // the raw error input drops ready in the very cycle the error flag rises
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready <= 1'b0;
    end else begin
      ready <= (state == st_run) && !err_flag && !major_err && ctrl[CTRL_LINK_OK];
    end
  end

  always_comb begin
    area_in = '0;
    area_in[POS_WARNING] = warn_flag;
    area_in[POS_INIT_PROC] = proc_req;
    area_in[POS_INIT_SET] = set_done && ctrl[CTRL_SET_EN];
    area_in[POS_ERROR] = err_flag;
    area_in[POS_READY] = ready;
  end

  assign link_input_bits = ctrl[CTRL_WORD_AREA] ? '0 : area_in;
  assign link_input_words = ctrl[CTRL_WORD_AREA] ? area_in : '0;

  // address decode, shared by the write and read paths
  logic hit_ctrl;
  logic hit_status;
  logic hit_event;
  logic hit_mask;
  logic hit_err_code;
  logic hit_warn_code;
  logic hit_start;
  logic wr_low;
  logic rd_setup;
  logic [31:0] next_rdata;

  assign hit_ctrl = (paddr == ADDR_CTRL);
  assign hit_status = (paddr == ADDR_STATUS);
  assign hit_event = (paddr == ADDR_EVENT);
  assign hit_mask = (paddr == ADDR_MASK);
  assign hit_err_code = (paddr == ADDR_ERR_CODE);
  assign hit_warn_code = (paddr == ADDR_WARN_CODE);
  assign hit_start = (paddr == ADDR_START);
  // the low byte lane alone gates a write, though the start number also takes bits 11:8 from lane 1
  assign wr_low = wr && pstrb[0];
  // read data is captured in the setup cycle and stands through the access phase
  assign rd_setup = psel && !penable && !pwrite;

  // control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
    end else if (wr_low && hit_ctrl) begin
      ctrl <= pwdata[4:0];
    end
  end

  // interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask <= MASK_RESET;
    end else if (wr_low && hit_mask) begin
      mask <= pwdata[3:0];
    end
  end

  // start number, readable back and driven out on area_start; the flag layout does not move with it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      area_start <= '0;
    end else if (wr_low && hit_start) begin
      area_start <= pwdata[START_W-1:0];
    end
  end

  // sticky events; set beats the write-one clear
  assign ev_set[EV_ERR_RESET] = err_reset_req;
  assign ev_set[EV_WARN_CLEAR] = minor_cause_gone && warn_flag;
  assign ev_set[EV_PROC_DONE] = master_proc_done && proc_req;
  assign ev_set[EV_SET_REQ] = master_set_req && !set_done;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_st <= EVENT_RESET;
    end else if (wr_low && hit_event) begin
      event_st <= (event_st & ~pwdata[3:0]) | ev_set;
    end else begin
      event_st <= event_st | ev_set;
    end
  end

  // registered so the pin never glitches while status and mask change together
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(event_st & mask);
    end
  end

  always_comb begin
    next_rdata = 32'h0;
    if (hit_ctrl) begin
      next_rdata = {27'h0, ctrl};
    end else if (hit_status) begin
      next_rdata = {14'h0, state, area_out};
    end else if (hit_event) begin
      next_rdata = {28'h0, event_st};
    end else if (hit_mask) begin
      next_rdata = {28'h0, mask};
    end else if (hit_err_code) begin
      next_rdata = {{(32-CODE_W){1'b0}}, err_code};
    end else if (hit_warn_code) begin
      next_rdata = {{(32-CODE_W){1'b0}}, warn_code};
    end else if (hit_start) begin
      next_rdata = {{(32-START_W){1'b0}}, area_start};
    end
  end

  // read data stands until the next read setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd_setup) begin
      prdata <= next_rdata;
    end
  end

endmodule : sys_area_handshake

// File: verilog/sys_area_pkg.sv
// constants shared by the link system-area handshake block
package sys_area_pkg;
  // bit offsets inside the 16-bit system area
  localparam int unsigned POS_WARNING = 7;
  localparam int unsigned POS_INIT_PROC = 8;
  localparam int unsigned POS_INIT_SET = 9;
  localparam int unsigned POS_ERROR = 10;
  localparam int unsigned POS_READY = 11;
  localparam int unsigned AREA_BITS = 16;
  // register byte offsets
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_EVENT = 12'h008;
  localparam logic [11:0] ADDR_MASK = 12'h00c;
  localparam logic [11:0] ADDR_ERR_CODE = 12'h010;
  localparam logic [11:0] ADDR_WARN_CODE = 12'h014;
  localparam logic [11:0] ADDR_START = 12'h018;
  // control register fields
  localparam int unsigned CTRL_PROC_EN = 0;
  localparam int unsigned CTRL_SET_EN = 1;
  localparam int unsigned CTRL_LINK_OK = 2;
  localparam int unsigned CTRL_SET_APPLIED = 3;
  localparam int unsigned CTRL_WORD_AREA = 4;
  // reset values
  localparam logic [4:0] CTRL_RESET = 5'h03;
  localparam logic [3:0] EVENT_RESET = 4'h0;
  localparam logic [3:0] MASK_RESET = 4'h0;
  // event bits
  localparam int unsigned EV_ERR_RESET = 0;
  localparam int unsigned EV_WARN_CLEAR = 1;
  localparam int unsigned EV_PROC_DONE = 2;
  localparam int unsigned EV_SET_REQ = 3;
  typedef enum logic [1:0] {
    st_init,
    st_run,
    st_error
  } hs_state_e;
endpackage : sys_area_pkg
